// ### pkg/tabc_pkg.sv
// Package for the touch area and backlight configuration block.
// Assumes a single 25 MHz clock domain and a synchronous active-high reset.
package tabc_pkg;
   // Register offsets on the plain register port (byte addresses)
   localparam logic [7:0] OFF_AREA_LO = 8'h00;
   localparam logic [7:0] OFF_AREA_HI = 8'h04;
   localparam logic [7:0] OFF_AREA_CMD = 8'h08;
   localparam logic [7:0] OFF_BL_CFG = 8'h0C;
   localparam logic [7:0] OFF_BRITE = 8'h10;
   localparam logic [7:0] OFF_TOUCH_CFG = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_BL_OUT = 8'h1C;
   localparam logic [7:0] OFF_NV_IMAGE = 8'h20;
   // Area id range
   localparam logic [7:0] AREA_ID_MIN = 8'h80;
   localparam logic [7:0] AREA_ID_MAX = 8'hFF;
   // Report characters
   localparam logic [7:0] CH_X = 8'h78;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   // Reset values
   localparam logic [7:0] RST_UPPER = 8'hFF;
   localparam logic [7:0] RST_LOWER = 8'h00;
   localparam logic [7:0] RST_SAMPLES = 8'h08;
   localparam logic [7:0] RST_SPAN = 8'h0C;
   localparam logic [7:0] RST_CAL_SEC = 8'h05;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int REPEAT_MS = 100;
   localparam int REPEAT_CYCLES = CLK_HZ / 1000 * REPEAT_MS;
   localparam int BEEP_MS = 50;
   localparam int BEEP_CYCLES = CLK_HZ / 1000 * BEEP_MS;

   typedef enum logic [2:0] {
      AT_VISIBLE, AT_REL, AT_REL_SILENT, AT_HIDDEN, AT_HIDDEN_SILENT, AT_REPEAT_SPECIAL
   } tabc_area_type_t;

   typedef struct packed {
      logic valid;
      tabc_area_type_t kind;
      logic rep_beep;
      logic [9:0] x0;
      logic [9:0] y0;
      logic [9:0] x1;
      logic [9:0] y1;
   } tabc_area_t;

   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
      logic down;
      logic pressure_ok;
   } tabc_touch_t;

   typedef struct packed {
      logic inv_pol;
      logic pwm_mode;
      logic [1:0] orient;
      logic [7:0] upper;
      logic [7:0] lower;
      logic lockout;
      logic pressure;
      logic wander;
      logic [7:0] samples;
      logic [7:0] span;
      logic [7:0] cal_sec;
   } tabc_cfg_t;

   typedef enum logic [3:0] {
      TX_IDLE, TX_X, TX_H, TX_T, TX_O, TX_SP1, TX_XH, TX_XT, TX_XO, TX_SP2, TX_YH, TX_YT, TX_YO, TX_CR
   } tabc_tx_state_t;
endpackage

// ### verilog/tabc_core.sv
// Touch area manager with backlight and panel configuration.
// Assumes touch samples arrive synchronous to clock; tx byte stream is drained by a UART with tx_ready.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module tabc_core #(
   parameter int NAREA = 8,
   parameter int REPEAT_CYC = tabc_pkg::REPEAT_CYCLES,
   parameter int BEEP_CYC = tabc_pkg::BEEP_CYCLES,
   parameter int SEC_CYC = tabc_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Touch sampler and calibration
   input wire tabc_pkg::tabc_touch_t touch_in,
   input wire logic [7:0] bright_req,
   input wire logic cal_start,
   output logic cal_timeout,
   // Report byte stream
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // Display and backlight pins
   output logic invert_on,
   output logic [9:0] inv_x0,
   output logic [9:0] inv_y0,
   output logic [9:0] inv_x1,
   output logic [9:0] inv_y1,
   output logic beep,
   output logic inverter_enable,
   output logic backlight_pwm_mode,
   output logic [7:0] bright_level,
   output logic bright_negative,
   output logic [1:0] panel_flip,
   output logic nv_store
);
   typedef struct packed {
      tabc_pkg::tabc_area_t [NAREA-1:0] area;
      tabc_pkg::tabc_cfg_t cfg;
      tabc_pkg::tabc_cfg_t nv;
      logic [63:0] area_w;
      logic [7:0] smp_cnt;
      logic [9:0] sx;
      logic [9:0] sy;
      logic valid_t;
      logic locked;
      logic [7:0] hit_id;
      logic [$clog2(NAREA+1)-1:0] hit;
      logic beeped;
      logic [31:0] rep_cnt;
      logic [31:0] beep_cnt;
      logic [31:0] cal_cnt;
      logic [7:0] cal_sec;
      logic cal_run;
      tabc_pkg::tabc_tx_state_t tx;
      logic [9:0] rx;
      logic [9:0] ry;
      logic [31:0] rdata;
      logic [7:0] out_level;
      logic out_inv;
      logic nv_w;
      logic ok_area;
   } tabc_state_t;

   tabc_state_t s_q, s_d;
   logic [NAREA-1:0] match;
   logic [$clog2(NAREA+1)-1:0] first;
   logic wander_out;
   logic [15:0] prod;

   // Area hit test per entry
   genvar gi;
   generate
      for (gi = 0; gi < NAREA; gi++) begin : g_hit
         assign match[gi] = s_q.area[gi].valid &&
            s_q.sx >= s_q.area[gi].x0 && s_q.sx <= s_q.area[gi].x1 &&
            s_q.sy >= s_q.area[gi].y0 && s_q.sy <= s_q.area[gi].y1;
      end
   endgenerate

   // Lowest slot wins; slots are kept by ascending id on write by software
   always_comb begin
      first = ($clog2(NAREA+1))'(NAREA);
      for (int i = NAREA-1; i >= 0; i--) begin
         if (match[i]) begin
            first = ($clog2(NAREA+1))'(i);
         end
      end
   end

   // Wander: distance from first press beyond span
   assign wander_out = (touch_in.x > s_q.sx ? touch_in.x - s_q.sx : s_q.sx - touch_in.x) > 10'(s_q.cfg.span) ||
      (touch_in.y > s_q.sy ? touch_in.y - s_q.sy : s_q.sy - touch_in.y) > 10'(s_q.cfg.span);

   // Brightness scale: lower + (upper-lower)*req/255 computed on magnitude
   always_comb begin
      if (s_q.cfg.upper >= s_q.cfg.lower) begin
         prod = 16'(s_q.cfg.upper - s_q.cfg.lower) * 16'(bright_req);
      end else begin
         prod = 16'(s_q.cfg.lower - s_q.cfg.upper) * 16'(bright_req);
      end
   end

   // Next state
   always_comb begin
      logic [7:0] id;
      logic [$clog2(NAREA)-1:0] slot;
      tabc_pkg::tabc_area_t na;
      id = reg_wdata[7:0];
      slot = reg_wdata[8 +: $clog2(NAREA)];
      na = '0;
      s_d = s_q;
      s_d.nv_w = 1'b0;
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            tabc_pkg::OFF_AREA_LO: s_d.area_w[31:0] = reg_wdata;
            tabc_pkg::OFF_AREA_HI: s_d.area_w[63:32] = reg_wdata;
            tabc_pkg::OFF_AREA_CMD: begin
               // cmd: [7:0] id, slot, [18:16] kind, [19] rep beep, [20] clear
               na.valid = ~reg_wdata[20];
               na.kind = tabc_pkg::tabc_area_type_t'(reg_wdata[18:16]);
               na.rep_beep = reg_wdata[19];
               {na.x0, na.y0, na.x1, na.y1} = {s_q.area_w[57:48], s_q.area_w[41:32], s_q.area_w[25:16],
                  s_q.area_w[9:0]};
               s_d.ok_area = id >= tabc_pkg::AREA_ID_MIN && id <= tabc_pkg::AREA_ID_MAX;
               if (s_d.ok_area) begin
                  s_d.area[slot] = na;
               end
            end
            tabc_pkg::OFF_BL_CFG: begin
               s_d.cfg.inv_pol = reg_wdata[0];
               s_d.cfg.pwm_mode = reg_wdata[1];
               s_d.cfg.orient = reg_wdata[3:2];
               s_d.cfg.cal_sec = reg_wdata[15:8];
               s_d.nv.inv_pol = reg_wdata[0];
               s_d.nv.pwm_mode = reg_wdata[1];
               s_d.nv.orient = reg_wdata[3:2];
               s_d.nv.cal_sec = reg_wdata[15:8];
               s_d.nv_w = 1'b1;
            end
            tabc_pkg::OFF_BRITE: begin
               s_d.cfg.upper = reg_wdata[7:0];
               s_d.cfg.lower = reg_wdata[15:8];
               s_d.nv.upper = reg_wdata[7:0];
               s_d.nv.lower = reg_wdata[15:8];
               s_d.nv_w = 1'b1;
            end
            tabc_pkg::OFF_TOUCH_CFG: begin
               s_d.cfg.lockout = reg_wdata[0];
               s_d.cfg.pressure = reg_wdata[1];
               s_d.cfg.wander = reg_wdata[2];
               s_d.cfg.samples = reg_wdata[15:8];
               s_d.cfg.span = reg_wdata[23:16];
               // Bit 31 is the no-store suffix: apply only
               if (!reg_wdata[31]) begin
                  s_d.nv.lockout = reg_wdata[0];
                  s_d.nv.pressure = reg_wdata[1];
                  s_d.nv.wander = reg_wdata[2];
                  s_d.nv.samples = reg_wdata[15:8];
                  s_d.nv.span = reg_wdata[23:16];
                  s_d.nv_w = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Reads never change settings, only return them
      s_d.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            tabc_pkg::OFF_AREA_LO: s_d.rdata = s_q.area_w[31:0];
            tabc_pkg::OFF_AREA_HI: s_d.rdata = s_q.area_w[63:32];
            tabc_pkg::OFF_BL_CFG: s_d.rdata = {16'h0000, s_q.cfg.cal_sec, 4'h0, s_q.cfg.orient,
               s_q.cfg.pwm_mode, s_q.cfg.inv_pol};
            tabc_pkg::OFF_BRITE: s_d.rdata = {16'h0000, s_q.cfg.lower, s_q.cfg.upper};
            tabc_pkg::OFF_TOUCH_CFG: s_d.rdata = {8'h00, s_q.cfg.span, s_q.cfg.samples, 5'h00, s_q.cfg.wander,
               s_q.cfg.pressure, s_q.cfg.lockout};
            tabc_pkg::OFF_STATUS: s_d.rdata = {14'h0000, s_q.ok_area, s_q.cal_run, s_q.hit_id, 6'h00,
               s_q.locked, s_q.valid_t};
            tabc_pkg::OFF_BL_OUT: s_d.rdata = {22'h000000, s_q.out_inv, s_q.out_level, s_q.cfg.pwm_mode};
            // Stored touch options, to tell applied from persisted
            tabc_pkg::OFF_NV_IMAGE: s_d.rdata = {8'h00, s_q.nv.span, s_q.nv.samples, 5'h00, s_q.nv.wander,
               s_q.nv.pressure, s_q.nv.lockout};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Touch qualification: count samples agreeing within span
      if (!touch_in.down || (s_q.cfg.pressure && !touch_in.pressure_ok) ||
          (s_q.smp_cnt != 8'h00 && wander_out)) begin
         s_d.smp_cnt = 8'h00;
         // Moving away after validation counts as release only with the wander option on
         // Low pressure only releases when the pressure option is on
         if (!touch_in.down || !s_q.valid_t || s_q.cfg.wander || (s_q.cfg.pressure && !touch_in.pressure_ok)) begin
            s_d.valid_t = 1'b0;
            s_d.locked = 1'b0;
            s_d.beeped = 1'b0;
         end
      end else begin
         if (s_q.smp_cnt == 8'h00) begin
            s_d.sx = touch_in.x;
            s_d.sy = touch_in.y;
         end
         if (s_q.smp_cnt != 8'hFF) begin
            s_d.smp_cnt = s_q.smp_cnt + 8'h01;
         end
         if (s_q.smp_cnt + 8'h01 >= s_q.cfg.samples) begin
            s_d.valid_t = 1'b1;
         end
      end
      // New press: pick area, report, beep
      s_d.rep_cnt = (s_q.rep_cnt != 32'h0) ? s_q.rep_cnt - 32'h1 : 32'h0;
      s_d.beep_cnt = (s_q.beep_cnt != 32'h0) ? s_q.beep_cnt - 32'h1 : 32'h0;
      if (s_q.valid_t && first != ($clog2(NAREA+1))'(NAREA) && s_q.tx == tabc_pkg::TX_IDLE) begin
         // Lockout keeps the first area until release
         if (!s_q.locked || (s_q.cfg.lockout && s_q.hit == first) || !s_q.cfg.lockout) begin
            if (!s_q.locked || s_q.hit != first ||
                (s_q.area[first].kind == tabc_pkg::AT_REPEAT_SPECIAL && s_q.rep_cnt == 32'h0)) begin
               s_d.locked = 1'b1;
               s_d.hit = first;
               s_d.hit_id = 8'h80 | 8'(first);
               s_d.rx = s_q.sx - s_q.area[first].x0;
               s_d.ry = s_q.sy - s_q.area[first].y0;
               s_d.tx = tabc_pkg::TX_X;
               s_d.rep_cnt = 32'(REPEAT_CYC);
               if (!(s_q.area[first].kind inside {tabc_pkg::AT_REL_SILENT, tabc_pkg::AT_HIDDEN_SILENT}) &&
                   (!s_q.beeped || s_q.area[first].rep_beep)) begin
                  s_d.beep_cnt = 32'(BEEP_CYC);
                  s_d.beeped = 1'b1;
               end
            end
         end
      end
      // Report serialiser, runs independently of command traffic
      if (s_q.tx != tabc_pkg::TX_IDLE && tx_ready) begin
         case (s_q.tx)
            tabc_pkg::TX_X: s_d.tx = tabc_pkg::TX_H;
            tabc_pkg::TX_H: s_d.tx = tabc_pkg::TX_T;
            tabc_pkg::TX_T: s_d.tx = tabc_pkg::TX_O;
            tabc_pkg::TX_O: s_d.tx = (s_q.area[s_q.hit].kind inside {tabc_pkg::AT_REL, tabc_pkg::AT_REL_SILENT}) ?
               tabc_pkg::TX_SP1 : tabc_pkg::TX_CR;
            tabc_pkg::TX_SP1: s_d.tx = tabc_pkg::TX_XH;
            tabc_pkg::TX_XH: s_d.tx = tabc_pkg::TX_XT;
            tabc_pkg::TX_XT: s_d.tx = tabc_pkg::TX_XO;
            tabc_pkg::TX_XO: s_d.tx = tabc_pkg::TX_SP2;
            tabc_pkg::TX_SP2: s_d.tx = tabc_pkg::TX_YH;
            tabc_pkg::TX_YH: s_d.tx = tabc_pkg::TX_YT;
            tabc_pkg::TX_YT: s_d.tx = tabc_pkg::TX_YO;
            tabc_pkg::TX_YO: s_d.tx = tabc_pkg::TX_CR;
            default: s_d.tx = tabc_pkg::TX_IDLE;
         endcase
      end
      // Calibration wait in whole seconds
      if (cal_start) begin
         s_d.cal_run = 1'b1;
         s_d.cal_cnt = 32'(SEC_CYC) - 32'h1;
         s_d.cal_sec = s_q.cfg.cal_sec;
      end else if (s_q.cal_run) begin
         if (s_q.valid_t || s_q.cal_sec == 8'h00) begin
            s_d.cal_run = 1'b0;
         end else if (s_q.cal_cnt == 32'h0) begin
            s_d.cal_cnt = 32'(SEC_CYC) - 32'h1;
            s_d.cal_sec = s_q.cal_sec - 8'h01;
         end else begin
            s_d.cal_cnt = s_q.cal_cnt - 32'h1;
         end
      end
      // Brightness level between limits
      s_d.out_inv = s_q.cfg.upper < s_q.cfg.lower;
      s_d.out_level = s_d.out_inv ? s_q.cfg.lower - 8'(prod / 16'd255) :
         s_q.cfg.lower + 8'(prod / 16'd255);
   end

   // Decimal digit of a value for the report text
   function automatic logic [7:0] dig(input logic [9:0] v, input int p);
      logic [9:0] q;
      q = (p == 2) ? v / 10'd100 : (p == 1) ? (v / 10'd10) % 10'd10 : v % 10'd10;
      return 8'h30 + 8'(q);
   endfunction

   // State register and pins, all flopped
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
         s_q.tx <= tabc_pkg::TX_IDLE;
         s_q.cfg.upper <= tabc_pkg::RST_UPPER;
         s_q.cfg.lower <= tabc_pkg::RST_LOWER;
         s_q.cfg.samples <= tabc_pkg::RST_SAMPLES;
         s_q.cfg.span <= tabc_pkg::RST_SPAN;
         s_q.cfg.cal_sec <= tabc_pkg::RST_CAL_SEC;
         reg_rdata <= 32'h00000000;
         tx_data <= 8'h00;
         tx_valid <= 1'b0;
         {invert_on, beep, inverter_enable, backlight_pwm_mode, bright_negative, nv_store, cal_timeout} <= 7'h00;
         {inv_x0, inv_y0, inv_x1, inv_y1} <= 40'h0000000000;
         bright_level <= 8'h00;
         panel_flip <= 2'h0;
      end else begin
         s_q <= s_d;
         reg_rdata <= s_d.rdata;
         tx_valid <= s_d.tx != tabc_pkg::TX_IDLE;
         case (s_d.tx)
            tabc_pkg::TX_X: tx_data <= tabc_pkg::CH_X;
            tabc_pkg::TX_H: tx_data <= dig(10'(s_d.hit_id), 2);
            tabc_pkg::TX_T: tx_data <= dig(10'(s_d.hit_id), 1);
            tabc_pkg::TX_O: tx_data <= dig(10'(s_d.hit_id), 0);
            tabc_pkg::TX_SP1, tabc_pkg::TX_SP2: tx_data <= tabc_pkg::CH_SP;
            tabc_pkg::TX_XH: tx_data <= dig(s_d.rx, 2);
            tabc_pkg::TX_XT: tx_data <= dig(s_d.rx, 1);
            tabc_pkg::TX_XO: tx_data <= dig(s_d.rx, 0);
            tabc_pkg::TX_YH: tx_data <= dig(s_d.ry, 2);
            tabc_pkg::TX_YT: tx_data <= dig(s_d.ry, 1);
            tabc_pkg::TX_YO: tx_data <= dig(s_d.ry, 0);
            default: tx_data <= tabc_pkg::CH_CR;
         endcase
         // Only plain visible areas invert while held
         invert_on <= s_d.locked && s_d.valid_t && s_d.area[s_d.hit].kind == tabc_pkg::AT_VISIBLE;
         {inv_x0, inv_y0, inv_x1, inv_y1} <= {s_d.area[s_d.hit].x0, s_d.area[s_d.hit].y0,
            s_d.area[s_d.hit].x1, s_d.area[s_d.hit].y1};
         beep <= s_d.beep_cnt != 32'h0;
         inverter_enable <= s_d.cfg.inv_pol;
         backlight_pwm_mode <= s_d.cfg.pwm_mode;
         bright_level <= s_d.out_level;
         bright_negative <= s_d.out_inv;
         panel_flip <= s_d.cfg.orient;
         nv_store <= s_d.nv_w;
         cal_timeout <= s_q.cal_run && !s_d.cal_run && !s_q.valid_t;
      end
   end

   // Checks
   property p_flip; @(posedge clock) disable iff (rst) 1 |=> panel_flip == $past(s_d.cfg.orient); endproperty
   a_flip: assert property (p_flip) else $error("flip outputs wrong");
   property p_nostore; @(posedge clock) disable iff (rst)
      reg_wr && reg_addr == tabc_pkg::OFF_TOUCH_CFG && reg_wdata[31] |=> !nv_store; endproperty
   a_nostore: assert property (p_nostore) else $error("suffix write stored");
   property p_id; @(posedge clock) disable iff (rst)
      reg_wr && reg_addr == tabc_pkg::OFF_AREA_CMD && reg_wdata[7:0] < 8'h80 |=> $stable(s_q.area); endproperty
   a_id: assert property (p_id) else $error("bad id accepted");
   property p_report; @(posedge clock) disable iff (rst)
      tx_valid && tx_data == tabc_pkg::CH_X |-> s_q.tx == tabc_pkg::TX_X; endproperty
   a_report: assert property (p_report) else $error("report start wrong");
   property p_noinv; @(posedge clock) disable iff (rst)
      invert_on |-> s_q.area[s_q.hit].kind == tabc_pkg::AT_VISIBLE; endproperty
   a_noinv: assert property (p_noinv) else $error("hidden area inverted");
   property p_silent; @(posedge clock) disable iff (rst)
      $rose(beep) |-> !(s_q.area[s_q.hit].kind inside {tabc_pkg::AT_REL_SILENT, tabc_pkg::AT_HIDDEN_SILENT});
   endproperty
   a_silent: assert property (p_silent) else $error("silent area beeped");
   property p_pol; @(posedge clock) disable iff (rst) 1'b1 |-> inverter_enable == s_q.cfg.inv_pol; endproperty
   a_pol: assert property (p_pol) else $error("enable polarity wrong");
   property p_bneg; @(posedge clock) disable iff (rst)
      s_q.cfg.upper > s_q.cfg.lower ##1 $stable(s_q.cfg) |=> !bright_negative; endproperty
   a_bneg: assert property (p_bneg) else $error("brightness polarity wrong");
   c_press: cover property (@(posedge clock) disable iff (rst) $rose(invert_on));
   c_rel: cover property (@(posedge clock) disable iff (rst) tx_valid && s_q.tx == tabc_pkg::TX_SP1);
   c_cal: cover property (@(posedge clock) disable iff (rst) cal_timeout);
endmodule

// ### verification/tabc_host_model.sv
// Host side model: takes report bytes off the core's stream.
// Assumes tx_valid holds a byte until tx_ready is seen high.
`timescale 1ns/100ps
module tabc_host_model (
   // Clock
   input wire logic clock,
   // Report stream
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Bench control
   input wire logic stall
);
   logic [7:0] rx [0:63];
   int n_rx = 0;
   logic [3:0] cnt_q = 4'h0;
   // Free counter gives a slow uptake pattern while stalling
   always @(posedge clock) begin
      cnt_q <= cnt_q + 4'h1;
   end
   assign tx_ready = !stall || cnt_q[3];
   // Bytes are taken whenever they come, also mid-command
   always @(posedge clock) begin
      if (tx_valid && tx_ready && n_rx < 64) begin
         rx[n_rx] <= tx_data;
         n_rx <= n_rx + 1;
      end
   end
endmodule

// ### verification/tb_top.sv
// Bench for the touch area and backlight core.
// Assumes short timing parameters; the host model drains reports.
`timescale 1ns/100ps
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   tabc_pkg::tabc_touch_t touch_in = '0;
   logic [7:0] bright_req = 8'h00;
   logic cal_start = 1'b0;
   logic cal_timeout, tx_valid, tx_ready, invert_on, beep, inverter_enable;
   logic backlight_pwm_mode, bright_negative, nv_store;
   logic stall = 1'b0;
   int n_beep = 0;
   logic [7:0] tx_data, bright_level;
   logic [9:0] inv_x0, inv_y0, inv_x1, inv_y1;
   logic [1:0] panel_flip;
   logic [31:0] rv;
   int n_mismatch = 0;
   int compares = 0;
   int n_nv = 0;
   int base, n, nb;
   // Clock at 25 MHz
   always #20 clock = ~clock;
   always @(posedge clock) begin
      if (nv_store === 1'b1) n_nv <= n_nv + 1;
      if (beep === 1'b1) n_beep <= n_beep + 1;
   end
   tabc_core #(.NAREA(16), .REPEAT_CYC(20), .BEEP_CYC(4), .SEC_CYC(10)) tabc_core_i (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .touch_in(touch_in), .bright_req(bright_req),
      .cal_start(cal_start), .cal_timeout(cal_timeout), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .invert_on(invert_on), .inv_x0(inv_x0), .inv_y0(inv_y0),
      .inv_x1(inv_x1), .inv_y1(inv_y1), .beep(beep), .inverter_enable(inverter_enable),
      .backlight_pwm_mode(backlight_pwm_mode), .bright_level(bright_level),
      .bright_negative(bright_negative), .panel_flip(panel_flip), .nv_store(nv_store));
   tabc_host_model host_i (.clock(clock), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .stall(stall));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // One-cycle strobes, changed just after the edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      // Data stand in the cycle after the strobe; take them at its closing edge
      @(posedge clock);
      rv = reg_rdata;
   endtask
   task area(input int id, kind, x0, y0, x1, y1);
      wr(tabc_pkg::OFF_AREA_LO, 32'((x1 << 16) | y1));
      wr(tabc_pkg::OFF_AREA_HI, 32'((x0 << 16) | y0));
      wr(tabc_pkg::OFF_AREA_CMD, 32'((kind << 16) | ((id - 128) << 8) | id));
   endtask
   function automatic logic [7:0] dg(input int v, input int d);
      return 8'h30 + 8'((v / d) % 10);
   endfunction
   // Press, wait for the whole report, check it, then release
   task press(input int x, y, id, rel, dx, dy, logic inv);
      logic [7:0] e[$];
      e = {tabc_pkg::CH_X, dg(id, 100), dg(id, 10), dg(id, 1)};
      if (rel) e = {e, tabc_pkg::CH_SP, dg(dx, 100), dg(dx, 10), dg(dx, 1),
         tabc_pkg::CH_SP, dg(dy, 100), dg(dy, 10), dg(dy, 1)};
      e.push_back(tabc_pkg::CH_CR);
      base = host_i.n_rx;
      nb = n_beep;
      touch_in <= '{10'(x), 10'(y), 1'b1, 1'b1};
      for (int i = 0; i < 600 && host_i.n_rx < base + e.size(); i++) @(posedge clock);
      for (int i = 0; i < e.size(); i++) check(32'(host_i.rx[base + i]), 32'(e[i]));
      check(32'(invert_on), 32'(inv));
      touch_in <= '0;
      repeat (10) @(posedge clock);
      check(32'(invert_on), 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      // Backlight pins follow the settings; queries read back
      wr(tabc_pkg::OFF_BL_CFG, 32'h0000050F);
      repeat (2) @(posedge clock);
      check(32'({inverter_enable, backlight_pwm_mode, panel_flip}), 32'hF);
      rd(tabc_pkg::OFF_BL_CFG);
      check(rv, 32'h0000050F);
      wr(tabc_pkg::OFF_BL_CFG, 32'h00000500);
      repeat (2) @(posedge clock);
      check(32'({inverter_enable, backlight_pwm_mode, panel_flip}), 32'h0);
      $display("test backlight done");
      // Negative polarity: upper 0, lower 230
      wr(tabc_pkg::OFF_BRITE, 32'h0000E600);
      bright_req <= 8'hFF;
      repeat (3) @(posedge clock);
      #1 check(32'({bright_negative, bright_level}), 32'h100);
      bright_req <= 8'h00;
      repeat (3) @(posedge clock);
      #1 check(32'(bright_level), 32'hE6);
      wr(tabc_pkg::OFF_BRITE, 32'h000000FF);
      bright_req <= 8'h50;
      repeat (3) @(posedge clock);
      #1 check(32'({bright_negative, bright_level}), 32'h050);
      $display("test brightness done");
      // Suffix option applies without a store, plain write stores
      n = n_nv;
      wr(tabc_pkg::OFF_TOUCH_CFG, 32'h800C0800);
      repeat (5) @(posedge clock);
      check(32'(n_nv - n), 32'h0);
      wr(tabc_pkg::OFF_TOUCH_CFG, 32'h000C0800);
      repeat (5) @(posedge clock);
      check(32'(n_nv - n), 32'h1);
      $display("test store done");
      // Visible and relative areas, host stalling on the second
      area(135, 0, 100, 100, 179, 139);
      area(140, 1, 100, 120, 200, 220);
      press(120, 110, 135, 0, 0, 0, 1'b1);
      check(32'({inv_x0, inv_y0}), 32'h00019064);
      check(32'({inv_x1, inv_y1}), 32'h0002CC8B);
      stall <= 1'b1;
      press(110, 140, 140, 1, 10, 20, 1'b0);
      check(32'(n_beep - nb), 32'h4);
      stall <= 1'b0;
      // Hidden silent area reports quietly; repeating area resends, beeps once
      area(129, 4, 400, 0, 450, 50);
      press(420, 20, 129, 0, 0, 0, 1'b0);
      check(32'(n_beep - nb), 32'h0);
      area(130, 5, 300, 300, 350, 350);
      base = host_i.n_rx;
      nb = n_beep;
      touch_in <= '{10'd320, 10'd320, 1'b1, 1'b1};
      repeat (60) @(posedge clock);
      check(32'(host_i.n_rx - base >= 10), 32'h1);
      check(32'(host_i.rx[base + 5]), 32'(tabc_pkg::CH_X));
      check(32'(n_beep - nb), 32'h4);
      check(32'(invert_on), 32'h0);
      touch_in <= '0;
      repeat (10) @(posedge clock);
      $display("test reports done");
      // Pressure option refuses a touch without valid pressure
      wr(tabc_pkg::OFF_TOUCH_CFG, 32'h800C0802);
      base = host_i.n_rx;
      touch_in <= '{10'd120, 10'd110, 1'b1, 1'b0};
      repeat (100) @(posedge clock);
      check(32'(host_i.n_rx - base), 32'h0);
      rd(tabc_pkg::OFF_NV_IMAGE);
      check(rv, 32'h000C0800);
      rd(tabc_pkg::OFF_TOUCH_CFG);
      check(rv, 32'h000C0802);
      touch_in <= '0;
      $display("test pressure done");
      // Five seconds of ten cycles each
      @(posedge clock);
      cal_start <= 1'b1;
      @(posedge clock);
      cal_start <= 1'b0;
      n = 1;
      while (n < 80 && cal_timeout !== 1'b1) begin
         @(posedge clock);
         n++;
      end
      check(32'(n >= 49 && n <= 53), 32'h1);
      $display("test calibration done");
      // Low id refused; unmapped place reads zero
      wr(tabc_pkg::OFF_AREA_CMD, 32'h00000010);
      rd(tabc_pkg::OFF_STATUS);
      check(32'(rv[17]), 32'h0);
      rd(8'hFC);
      check(rv, 32'h0);
      $display("test refusal done");
      print_verdict;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      print_verdict;
   end
endmodule
